// >>> adcr_top.sv
/*
 * adc digital back end control registers: power modes, output format,
 * sync and system reference handling, dc offset correction, threshold
 * flag pin and multiframe phase counter.
 * assumes the serial control port delivers register accesses on the
 * sample clock, and that samples arrive as offset binary on that clock.
 * power-down pin, sync request and system reference come from pins.
 */
// Summary of operation
// - pin mode bit: power-down or standby
// - link standby follows pin when enabled and pin mode is standby
// - link power field: normal, off, standby
// - converter power field: normal, off, standby
// - output disable suppresses sample data
// - invert bit inverts output samples
// - format field: offset binary or twos complement
// - sync realign on each sync assertion
// - reference realign on each reference assertion
// - reference mode: every edge or next only
// - reference input ignored unless enabled
// - sync input buffer only when enabled
// - freeze holds last dc estimate
// - bandwidth code k, 14 and 15 as 13
// - correction adds dc block output to path
// - correction value low then high byte
// - flag function: threshold or overrange
// - force enable drives forced value on flag
// - detect enable lets comparator drive flag
// - upper threshold 15 bits across two bytes
// - flag set when magnitude above upper
// - flag clears after dwell below lower
// - offset loads phase counter on reference
`timescale 1ns/10ps

module adcr_top #(
	parameter int SAMPLE_W = 14,
	parameter logic [14:0] LOWER_THRESH = 15'h0000,
	parameter logic [15:0] DWELL_CYCLES = 16'h0001,
	parameter logic [4:0] MF_LENGTH = 5'h1f
) (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [7:0] lane_checksum_i,
	input wire logic powerdown_pin_i,
	input wire logic link_sync_request_in_b_i,
	input wire logic system_reference_in_i,
	input adcr_pkg::adcr_sample_t sample_i,
	output adcr_pkg::adcr_sample_t sample_o,
	output adcr_pkg::adcr_power_t power_o,
	output logic link_sync_request_o,
	output logic link_realign_o,
	output logic divider_reset_o,
	output logic local_multiframe_clock_o,
	output logic [4:0] mf_phase_o,
	output logic driver_pwrdn_o,
	output logic [7:0] driver_emphasis_o,
	output logic settings_transfer_o,
	output logic threshold_flag_pin_o
);
	import adcr_pkg::*;

	localparam int ACC_W = 44;

	// ==========================================================
	// helpers
	// clamp a 17-bit signed value into the sample range
	function automatic logic [13:0] sat14(input logic signed [16:0] v);
		logic [13:0] r;
		r = v[13:0];
		if (v > 17'sh01fff) begin
			r = 14'h1fff;
		end else if (v < -17'sh02000) begin
			r = 14'h2000;
		end
		return r;
	endfunction

	// rising edge of a synchronised level
	function automatic logic rise(input logic now, input logic was);
		return now & ~was;
	endfunction

	// ==========================================================
	// register storage
	logic [7:0] power_mode_control_reg;
	logic [7:0] output_format_control_reg;
	logic [7:0] sync_reference_control_reg;
	logic [7:0] offset_correction_control_reg;
	logic [7:0] threshold_flag_control_reg;
	logic [7:0] upper_threshold_low_reg;
	logic [7:0] upper_threshold_high_reg;
	logic [7:0] lane_driver_control_reg;
	logic [7:0] multiframe_phase_offset_reg;
	logic [7:0] driver_emphasis_reg;
	logic [7:0] reg_rdata_reg;
	logic [7:0] reg_rdata_next;

	// ==========================================================
	// pin synchronisers, two stages before any logic looks
	logic [1:0] pd_sync_reg;
	logic [1:0] sync_sync_reg;
	logic [1:0] ref_sync_reg;
	logic sync_prev_reg;
	logic ref_prev_reg;

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pd_sync_reg <= 2'h0;
			sync_sync_reg <= 2'h3;
			ref_sync_reg <= 2'h0;
		end else begin
			pd_sync_reg <= {pd_sync_reg[0], powerdown_pin_i};
			sync_sync_reg <= {sync_sync_reg[0], link_sync_request_in_b_i};
			ref_sync_reg <= {ref_sync_reg[0], system_reference_in_i};
		end
	end

	// ==========================================================
	// register write decode
	wire wr_power = reg_wr_i && reg_addr_i == ADCR_OFS_POWER;
	wire wr_format = reg_wr_i && reg_addr_i == ADCR_OFS_FORMAT;
	wire wr_syncref = reg_wr_i && reg_addr_i == ADCR_OFS_SYNCREF;
	wire wr_dc = reg_wr_i && reg_addr_i == ADCR_OFS_DC_CTRL;
	wire wr_flag = reg_wr_i && reg_addr_i == ADCR_OFS_FLAG_CTRL;
	wire wr_up_lo = reg_wr_i && reg_addr_i == ADCR_OFS_UPPER_LOW;
	wire wr_up_hi = reg_wr_i && reg_addr_i == ADCR_OFS_UPPER_HIGH;
	wire wr_driver = reg_wr_i && reg_addr_i == ADCR_OFS_DRIVER;
	wire wr_mf = reg_wr_i && reg_addr_i == ADCR_OFS_MF_OFFSET;
	wire wr_emph = reg_wr_i && reg_addr_i == ADCR_OFS_EMPHASIS;
	wire wr_xfer = reg_wr_i && reg_addr_i == ADCR_OFS_TRANSFER;

	// reserved bits are masked on write so they read as zero, except format bits 7:5
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			power_mode_control_reg <= ADCR_RST_ZERO;
			output_format_control_reg <= ADCR_RST_ZERO;
			sync_reference_control_reg <= ADCR_RST_SYNCREF;
			offset_correction_control_reg <= ADCR_RST_ZERO;
			threshold_flag_control_reg <= ADCR_RST_ZERO;
			upper_threshold_low_reg <= ADCR_RST_ZERO;
			upper_threshold_high_reg <= ADCR_RST_ZERO;
			lane_driver_control_reg <= ADCR_RST_ZERO;
			multiframe_phase_offset_reg <= ADCR_RST_ZERO;
			driver_emphasis_reg <= ADCR_RST_EMPHASIS;
		end else begin
			if (wr_power) power_mode_control_reg <= reg_wdata_i & 8'h3f;
			if (wr_format) output_format_control_reg <= reg_wdata_i & 8'hf7;
			if (wr_syncref) sync_reference_control_reg <= reg_wdata_i & 8'h1f;
			if (wr_dc) offset_correction_control_reg <= reg_wdata_i & 8'h7e;
			if (wr_flag) threshold_flag_control_reg <= reg_wdata_i & 8'h1d;
			if (wr_up_lo) upper_threshold_low_reg <= reg_wdata_i;
			if (wr_up_hi) upper_threshold_high_reg <= reg_wdata_i & 8'h7f;
			if (wr_driver) lane_driver_control_reg <= reg_wdata_i & 8'h02;
			if (wr_mf) multiframe_phase_offset_reg <= reg_wdata_i & 8'h1f;
			if (wr_emph) driver_emphasis_reg <= reg_wdata_i;
		end
	end

	// ==========================================================
	// field views
	wire pin_mode = power_mode_control_reg[ADCR_PWR_PIN_MODE];
	wire link_stby_en = power_mode_control_reg[ADCR_PWR_LINK_STBY];
	wire [1:0] link_mode = power_mode_control_reg[ADCR_PWR_LINK_LSB +: 2];
	wire [1:0] conv_mode = power_mode_control_reg[ADCR_PWR_CONV_LSB +: 2];
	wire out_disable = output_format_control_reg[ADCR_FMT_DISABLE];
	wire out_invert = output_format_control_reg[ADCR_FMT_INVERT];
	wire [1:0] fmt_sel = output_format_control_reg[ADCR_FMT_SEL_LSB +: 2];
	wire sync_realign = sync_reference_control_reg[ADCR_SR_SYNC_REALIGN];
	wire ref_realign = sync_reference_control_reg[ADCR_SR_REF_REALIGN];
	wire ref_mode = sync_reference_control_reg[ADCR_SR_REF_MODE];
	wire ref_en = sync_reference_control_reg[ADCR_SR_REF_EN];
	wire sync_en = sync_reference_control_reg[ADCR_SR_SYNC_EN];
	wire dc_freeze = offset_correction_control_reg[ADCR_DC_FREEZE];
	wire [3:0] dc_bw = offset_correction_control_reg[ADCR_DC_BW_LSB +: 4];
	wire dc_en = offset_correction_control_reg[ADCR_DC_EN];
	wire flag_func = threshold_flag_control_reg[ADCR_FL_FUNC];
	wire force_en = threshold_flag_control_reg[ADCR_FL_FORCE_EN];
	wire force_val = threshold_flag_control_reg[ADCR_FL_FORCE_VAL];
	wire detect_en = threshold_flag_control_reg[ADCR_FL_DETECT_EN];
	wire [14:0] upper_thresh = {upper_threshold_high_reg[6:0],
		upper_threshold_low_reg};

	// ==========================================================
	// power modes: pin effect combined with register fields
	wire pd_pin = pd_sync_reg[1];
	adcr_power_t power_next;
	assign power_next.conv_pwrdn = conv_mode == ADCR_MODE_PWRDN
		|| (pd_pin && !pin_mode);
	assign power_next.conv_standby = conv_mode == ADCR_MODE_STANDBY
		|| (pd_pin && pin_mode);
	assign power_next.link_pwrdn = link_mode == ADCR_MODE_PWRDN
		|| (pd_pin && !pin_mode);
	assign power_next.link_standby = link_mode == ADCR_MODE_STANDBY
		|| (pd_pin && pin_mode && link_stby_en);

	// ==========================================================
	// sync request and system reference events
	// a disabled buffer reads as deasserted, so no false realign
	wire sync_level = sync_en && !sync_sync_reg[1];
	wire ref_level = ref_en && ref_sync_reg[1];
	wire sync_assert = rise(sync_level, sync_prev_reg);
	wire ref_rise = rise(ref_level, ref_prev_reg);
	logic ref_armed_reg;
	// one-shot mode re-arms on each write that sets the mode bit
	wire ref_div_fire = ref_rise && (!ref_mode || ref_armed_reg);
	wire realign_next = (sync_realign && sync_assert)
		|| (ref_realign && ref_rise);

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync_prev_reg <= 1'b0;
			ref_prev_reg <= 1'b0;
			ref_armed_reg <= 1'b0;
		end else begin
			sync_prev_reg <= sync_level;
			ref_prev_reg <= ref_level;
			if (wr_syncref && reg_wdata_i[ADCR_SR_REF_MODE]) begin
				ref_armed_reg <= 1'b1;
			end else if (ref_rise) begin
				ref_armed_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// local multiframe phase counter
	logic [4:0] mf_phase_reg;
	wire mf_wrap = mf_phase_reg == MF_LENGTH;
	wire [4:0] mf_phase_next = ref_rise ? multiframe_phase_offset_reg[4:0]
		: (mf_wrap ? 5'h00 : mf_phase_reg + 5'h01);

	// ==========================================================
	// dc estimate: leaky integrator, shift sets the bandwidth
	logic signed [ACC_W-1:0] dc_acc_reg;
	wire [3:0] bw_clamped = (dc_bw > ADCR_BW_MAX) ? ADCR_BW_MAX : dc_bw;
	wire [4:0] bw_shift = ADCR_BW_SHIFT_BASE + {1'b0, bw_clamped};
	wire signed [ACC_W-1:0] dc_est_full = dc_acc_reg >>> bw_shift;
	wire signed [13:0] in_tc = {~sample_i.data[13], sample_i.data[12:0]};
	wire signed [ACC_W-1:0] dc_acc_next = dc_acc_reg
		+ ACC_W'(in_tc) - dc_est_full;
	wire [15:0] dc_corr = 16'(-dc_est_full[15:0]);

	// ==========================================================
	// sample path: correct, invert, format, disable
	wire signed [16:0] corr_sum = 17'(in_tc) + 17'($signed(dc_corr));
	wire [13:0] corrected = dc_en ? sat14(corr_sum) : in_tc;
	wire [13:0] inverted = out_invert ? ~corrected : corrected;
	wire [13:0] formatted = (fmt_sel == ADCR_FMT_TWOS) ? inverted
		: {~inverted[13], inverted[12:0]};
	adcr_sample_t sample_next;
	assign sample_next.valid = sample_i.valid && !out_disable;
	assign sample_next.over = sample_i.over && !out_disable;
	assign sample_next.data = out_disable ? 14'h0000 : formatted;

	// ==========================================================
	// threshold flag: magnitude of the corrected two's complement
	wire [14:0] magnitude = corrected[13] ? 15'(-$signed(corrected))
		: {1'b0, corrected};
	wire above_upper = sample_i.valid && magnitude > upper_thresh;
	wire below_lower = sample_i.valid && magnitude < LOWER_THRESH;
	adcr_flag_state_t flag_state_reg;
	adcr_flag_state_t flag_state_next;
	logic [15:0] dwell_reg;
	logic [15:0] dwell_next;

	// flag state: set on upper cross, clear after dwell below lower
	always_comb begin
		flag_state_next = flag_state_reg;
		dwell_next = 16'h0000;
		case (flag_state_reg)
			ADCR_FLAG_LOW: begin
				if (detect_en && above_upper) begin
					flag_state_next = ADCR_FLAG_HIGH;
				end
			end
			ADCR_FLAG_HIGH: begin
				if (!detect_en) begin
					flag_state_next = ADCR_FLAG_LOW;
				end else if (below_lower) begin
					dwell_next = dwell_reg + 16'h0001;
					if (dwell_next >= DWELL_CYCLES) begin
						flag_state_next = ADCR_FLAG_LOW;
					end
				end else if (!sample_i.valid) begin
					dwell_next = dwell_reg;
				end
			end
			default: begin
				flag_state_next = ADCR_FLAG_LOW;
			end
		endcase
	end

	// pin source: force beats the function select
	wire detect_flag = detect_en && flag_state_reg == ADCR_FLAG_HIGH;
	wire source_flag = flag_func ? sample_i.over : detect_flag;
	wire flag_pin_next = force_en ? force_val : source_flag;

	// ==========================================================
	// register read mux, reserved bits already zero in storage except format bits 7:5
	always_comb begin
		case (reg_addr_i)
			ADCR_OFS_POWER: reg_rdata_next = power_mode_control_reg;
			ADCR_OFS_FORMAT: reg_rdata_next = output_format_control_reg;
			ADCR_OFS_SYNCREF: reg_rdata_next = sync_reference_control_reg;
			ADCR_OFS_DC_CTRL: reg_rdata_next = offset_correction_control_reg;
			ADCR_OFS_DC_LOW: reg_rdata_next = dc_corr[7:0];
			ADCR_OFS_DC_HIGH: reg_rdata_next = dc_corr[15:8];
			ADCR_OFS_FLAG_CTRL: reg_rdata_next = threshold_flag_control_reg;
			ADCR_OFS_UPPER_LOW: reg_rdata_next = upper_threshold_low_reg;
			ADCR_OFS_UPPER_HIGH: reg_rdata_next = upper_threshold_high_reg;
			ADCR_OFS_CHECKSUM: reg_rdata_next = lane_checksum_i;
			ADCR_OFS_DRIVER: reg_rdata_next = lane_driver_control_reg;
			ADCR_OFS_MF_OFFSET: reg_rdata_next = multiframe_phase_offset_reg;
			ADCR_OFS_EMPHASIS: reg_rdata_next = driver_emphasis_reg;
			default: reg_rdata_next = 8'h00;
		endcase
	end

	// ==========================================================
	// state updates and registered outputs
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dc_acc_reg <= '0;
			mf_phase_reg <= 5'h00;
			flag_state_reg <= ADCR_FLAG_LOW;
			dwell_reg <= 16'h0000;
		end else begin
			// freeze keeps the last estimate, correction still applies
			if (sample_i.valid && !dc_freeze) begin
				dc_acc_reg <= dc_acc_next;
			end
			mf_phase_reg <= mf_phase_next;
			flag_state_reg <= flag_state_next;
			dwell_reg <= dwell_next;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sample_o <= '0;
			power_o <= '0;
			reg_rdata_reg <= 8'h00;
			link_sync_request_o <= 1'b0;
			link_realign_o <= 1'b0;
			divider_reset_o <= 1'b0;
			local_multiframe_clock_o <= 1'b0;
			settings_transfer_o <= 1'b0;
			threshold_flag_pin_o <= 1'b0;
		end else begin
			sample_o <= sample_next;
			power_o <= power_next;
			if (reg_rd_i) reg_rdata_reg <= reg_rdata_next;
			link_sync_request_o <= sync_level;
			link_realign_o <= realign_next;
			divider_reset_o <= ref_div_fire;
			local_multiframe_clock_o <= mf_wrap || ref_rise;
			settings_transfer_o <= wr_xfer && reg_wdata_i[ADCR_XFER_BIT];
			threshold_flag_pin_o <= flag_pin_next;
		end
	end

	assign reg_rdata_o = reg_rdata_reg;
	assign mf_phase_o = mf_phase_reg;
	assign driver_pwrdn_o = lane_driver_control_reg[ADCR_DRV_PWRDN];
	assign driver_emphasis_o = driver_emphasis_reg;

endmodule

// >>> adcr_pkg.sv
/*
 * constants and carrier types for the adc digital control register bank.
 * assumes an 8-bit register address and 8-bit register data path
 * supplied by the serial control port logic on the sample clock.
 */
package adcr_pkg;

	// ==========================================================
	// register offsets
	localparam logic [7:0] ADCR_OFS_POWER = 8'h08;
	localparam logic [7:0] ADCR_OFS_FORMAT = 8'h14;
	localparam logic [7:0] ADCR_OFS_SYNCREF = 8'h3a;
	localparam logic [7:0] ADCR_OFS_DC_CTRL = 8'h40;
	localparam logic [7:0] ADCR_OFS_DC_LOW = 8'h41;
	localparam logic [7:0] ADCR_OFS_DC_HIGH = 8'h42;
	localparam logic [7:0] ADCR_OFS_FLAG_CTRL = 8'h45;
	localparam logic [7:0] ADCR_OFS_UPPER_LOW = 8'h47;
	localparam logic [7:0] ADCR_OFS_UPPER_HIGH = 8'h48;
	localparam logic [7:0] ADCR_OFS_CHECKSUM = 8'h79;
	localparam logic [7:0] ADCR_OFS_DRIVER = 8'h80;
	localparam logic [7:0] ADCR_OFS_MF_OFFSET = 8'h8b;
	localparam logic [7:0] ADCR_OFS_EMPHASIS = 8'ha8;
	localparam logic [7:0] ADCR_OFS_TRANSFER = 8'hff;

	// ==========================================================
	// field positions
	localparam int ADCR_PWR_PIN_MODE = 5;
	localparam int ADCR_PWR_LINK_STBY = 4;
	localparam int ADCR_PWR_LINK_LSB = 2;
	localparam int ADCR_PWR_CONV_LSB = 0;
	localparam int ADCR_FMT_DISABLE = 4;
	localparam int ADCR_FMT_INVERT = 2;
	localparam int ADCR_FMT_SEL_LSB = 0;
	localparam int ADCR_SR_SYNC_REALIGN = 4;
	localparam int ADCR_SR_REF_REALIGN = 3;
	localparam int ADCR_SR_REF_MODE = 2;
	localparam int ADCR_SR_REF_EN = 1;
	localparam int ADCR_SR_SYNC_EN = 0;
	localparam int ADCR_DC_FREEZE = 6;
	localparam int ADCR_DC_BW_LSB = 2;
	localparam int ADCR_DC_EN = 1;
	localparam int ADCR_FL_FUNC = 4;
	localparam int ADCR_FL_FORCE_EN = 3;
	localparam int ADCR_FL_FORCE_VAL = 2;
	localparam int ADCR_FL_DETECT_EN = 0;
	localparam int ADCR_DRV_PWRDN = 1;
	localparam int ADCR_XFER_BIT = 0;

	// ==========================================================
	// field codes and reset values
	localparam logic [1:0] ADCR_MODE_NORMAL = 2'h0;
	localparam logic [1:0] ADCR_MODE_PWRDN = 2'h1;
	localparam logic [1:0] ADCR_MODE_STANDBY = 2'h2;
	localparam logic [1:0] ADCR_FMT_OFFSET_BIN = 2'h0;
	localparam logic [1:0] ADCR_FMT_TWOS = 2'h1;
	localparam logic [3:0] ADCR_BW_MAX = 4'hd;
	localparam logic [4:0] ADCR_BW_SHIFT_BASE = 5'h0e;
	localparam logic [7:0] ADCR_RST_ZERO = 8'h00;
	localparam logic [7:0] ADCR_RST_SYNCREF = 8'h01;
	localparam logic [7:0] ADCR_RST_EMPHASIS = 8'h04;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic valid;
		logic over;
		logic [13:0] data;
	} adcr_sample_t;

	typedef struct packed {
		logic conv_pwrdn;
		logic conv_standby;
		logic link_pwrdn;
		logic link_standby;
	} adcr_power_t;

	typedef enum logic [1:0] {
		ADCR_FLAG_LOW = 2'b01,
		ADCR_FLAG_HIGH = 2'b10
	} adcr_flag_state_t;

endpackage

// >>> adcr_regs_monitor.sv
/* concurrent checks on the adc control register bank top ports.
   assumes one sample clock and the async active-low reset. */
`timescale 1ns/10ps
module adcr_regs_monitor (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [7:0] lane_checksum_i,
	input adcr_pkg::adcr_sample_t sample_i,
	input adcr_pkg::adcr_sample_t sample_o,
	input wire logic link_sync_request_o,
	input wire logic link_realign_o,
	input wire logic divider_reset_o,
	input wire logic settings_transfer_o,
	input wire logic threshold_flag_pin_o
);
	import adcr_pkg::*;
	// ==========================================================
	// shadows of the control bits, updated on the write edge
	logic dis_reg, sen_reg, ren_reg, fe_reg, fv_reg;
	logic [2:0] roff_reg;
	wire wr_fmt = reg_wr_i && (reg_addr_i == ADCR_OFS_FORMAT);
	wire wr_sr = reg_wr_i && (reg_addr_i == ADCR_OFS_SYNCREF);
	wire wr_fl = reg_wr_i && (reg_addr_i == ADCR_OFS_FLAG_CTRL);
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			{dis_reg, ren_reg, fe_reg, fv_reg} <= 4'h0;
			sen_reg <= 1'b1; // sync buffer on out of reset
		end else begin
			if (wr_fmt) dis_reg <= reg_wdata_i[ADCR_FMT_DISABLE];
			if (wr_sr) {ren_reg, sen_reg} <= reg_wdata_i[1:0];
			if (wr_fl) {fe_reg, fv_reg} <= reg_wdata_i[3:2];
		end
	end
	// cycles with the reference disabled; 7 covers the pin pipeline
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) roff_reg <= 3'h0;
		else if (ren_reg) roff_reg <= 3'h0;
		else if (roff_reg != 3'h7) roff_reg <= roff_reg + 3'h1;
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	// ==========================================================
	// assertions
	AST_FORCE: assert property ($past(fe_reg) |->
		threshold_flag_pin_o == $past(fv_reg)) else $error("flag not forced");
	AST_DISABLE: assert property ($past(dis_reg) |->
		sample_o == '0) else $error("disabled output not zero");
	AST_VALID: assert property ($past(rst_b_i) && !$past(dis_reg) |->
		sample_o.valid == $past(sample_i.valid)) else $error("valid lost");
	AST_SYNC_OFF: assert property (!$past(sen_reg) |->
		!link_sync_request_o) else $error("sync passed while off");
	AST_REF_OFF: assert property (roff_reg == 3'h7 |->
		!divider_reset_o) else $error("reference taken while off");
	AST_RA_PULSE: assert property (link_realign_o |=>
		!link_realign_o) else $error("realign pulse too wide");
	AST_DR_PULSE: assert property (divider_reset_o |=>
		!divider_reset_o) else $error("divider pulse too wide");
	AST_CHKSUM: assert property (reg_rd_i && reg_addr_i == ADCR_OFS_CHECKSUM
		|=> reg_rdata_o == $past(lane_checksum_i)) else $error("checksum");
	AST_UNMAP: assert property (reg_rd_i && reg_addr_i == 8'h50 |=>
		reg_rdata_o == 8'h00) else $error("unmapped read not zero");
	AST_XFER: assert property (reg_wr_i && reg_addr_i == ADCR_OFS_TRANSFER
		&& reg_wdata_i[0] |-> ##[1:2] (settings_transfer_o ##1
		!settings_transfer_o)) else $error("transfer pulse missing");
	COV_RA: cover property (link_realign_o);
	COV_FLAG: cover property ($rose(threshold_flag_pin_o));
	COV_DR: cover property (divider_reset_o);
endmodule
bind adcr_top adcr_regs_monitor u_mon (.sys_clk_i, .rst_b_i, .reg_addr_i,
	.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .lane_checksum_i,
	.sample_i, .sample_o, .link_sync_request_o, .link_realign_o,
	.divider_reset_o, .settings_transfer_o, .threshold_flag_pin_o);

// >>> adcr_pin_model.sv
/* link-side pin model: system reference and sync request pulses.
   assumes requests at least a pulse width apart, on the sample clock. */
`timescale 1ns/10ps
module adcr_pin_model (
	input wire logic sys_clk_i,
	input wire logic ref_req_i,
	input wire logic sync_req_i,
	input wire logic wide_i,
	output logic system_reference_o,
	output logic link_sync_request_b_o
);
	int ref_cnt = 0;
	int sync_cnt = 0;
	// 2 or 5 cycle pulses, taken on the edge so no race with the bench
	always @(posedge sys_clk_i) begin
		if (ref_req_i) ref_cnt <= wide_i ? 5 : 2;
		else if (ref_cnt > 0) ref_cnt <= ref_cnt - 1;
		if (sync_req_i) sync_cnt <= wide_i ? 5 : 2;
		else if (sync_cnt > 0) sync_cnt <= sync_cnt - 1;
	end
	assign system_reference_o = (ref_cnt > 0);
	assign link_sync_request_b_o = !(sync_cnt > 0); // active low
endmodule

// >>> tb.sv
/* self-checking bench for the adc control register bank.
   assumes the pin model beside it; checks from constants and from earlier register reads. */
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
	$display("wrong value at %0t: %h want %h", $time, g, e); end end
module tb;
	import adcr_pkg::*;
	logic sys_clk_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0, pd = 0;
	logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, rdata, lo, hi, rb;
	logic ref_req = 0, sync_req = 0, wide = 0, system_reference_in, sync_b;
	logic ra, dr, flag, sreq, dpd;
	logic [4:0] phase, ph;
	logic [7:0] emph;
	logic [12:0] ptab [7];
	logic [21:0] ftab [4];
	adcr_sample_t smp = '0, sout;
	adcr_power_t pwr;
	int err_total = 0, n_checks = 0, cyc = 0, n_ra, n_dr, n_sr;
	adcr_top #(.LOWER_THRESH(15'h0080), .DWELL_CYCLES(16'h0003)) u_dut (
		.sys_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
		.reg_rd_i, .reg_rdata_o(rdata), .lane_checksum_i(8'h5a),
		.powerdown_pin_i(pd), .link_sync_request_in_b_i(sync_b),
		.system_reference_in_i(system_reference_in), .sample_i(smp), .sample_o(sout),
		.power_o(pwr), .link_sync_request_o(sreq), .link_realign_o(ra),
		.divider_reset_o(dr), .local_multiframe_clock_o(),
		.mf_phase_o(phase), .driver_pwrdn_o(dpd), .driver_emphasis_o(emph),
		.settings_transfer_o(), .threshold_flag_pin_o(flag));
	adcr_pin_model u_pins (.sys_clk_i, .ref_req_i(ref_req),
		.sync_req_i(sync_req), .wide_i(wide), .system_reference_o(system_reference_in),
		.link_sync_request_b_o(sync_b));
	// ==========================================================
	// clock, hang guard and closing report
	initial forever #5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 20000) begin // far beyond the ~700 cycles needed
			err_total++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ==========================================================
	// access tasks: one-cycle strobes launched 1 ns after the edge
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		settle(1);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		settle(1);
		reg_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		settle(1);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		settle(1);
		reg_rd_i = 1'b0;
		d = rdata;
	endtask
	// one pin request, then count what comes out over 12 cycles
	task automatic pin(input logic r, input logic s);
		settle(1);
		{ref_req, sync_req} = {r, s};
		settle(1);
		{ref_req, sync_req, n_ra, n_dr, n_sr} = '0;
		repeat (12) begin
			settle(1);
			n_ra += int'(ra === 1'b1);
			n_sr += int'(sreq === 1'b1);
			if (dr === 1'b1) ph = phase;
			n_dr += int'(dr === 1'b1);
		end
	endtask
	initial begin
		// reg value, pin, expected {conv_pd, conv_sb, link_pd, link_sb}
		ptab = '{{8'h05, 1'b0, 4'b1010}, {8'h0a, 1'b0, 4'b0101},
			{8'h00, 1'b1, 4'b1010}, {8'h20, 1'b1, 4'b0100},
			{8'h30, 1'b1, 4'b0101}, {8'h10, 1'b1, 4'b1010},
			{8'h30, 1'b0, 4'b0000}};
		// format register, expected data for raw 0x2100
		ftab = '{{8'h00, 14'h2100}, {8'h01, 14'h0100},
			{8'h05, 14'h3eff}, {8'h04, 14'h1eff}};
		settle(6);
		rst_b_i = 1'b1;
		// register reset values, access kinds and reserved bits
		rd(ADCR_OFS_SYNCREF, lo); `CHK(lo, ADCR_RST_SYNCREF)
		rd(ADCR_OFS_EMPHASIS, lo); `CHK(lo, ADCR_RST_EMPHASIS)
		`CHK(emph, 8'h04)
		wr(ADCR_OFS_DRIVER, 8'hff); `CHK(dpd, 1'b1)
		rd(ADCR_OFS_MF_OFFSET, lo); `CHK(lo, 8'h00)
		rd(8'h50, lo); `CHK(lo, 8'h00)
		wr(ADCR_OFS_CHECKSUM, 8'h00);
		rd(ADCR_OFS_CHECKSUM, lo); `CHK(lo, 8'h5a)
		wr(ADCR_OFS_MF_OFFSET, 8'hff);
		rd(ADCR_OFS_MF_OFFSET, lo); `CHK(lo, 8'h1f)
		wr(ADCR_OFS_FLAG_CTRL, 8'hff);
		rd(ADCR_OFS_FLAG_CTRL, lo); `CHK(lo, 8'h1d)
		wr(ADCR_OFS_UPPER_HIGH, 8'hff);
		rd(ADCR_OFS_UPPER_HIGH, lo); `CHK(lo, 8'h7f)
		$display("test registers done");
		// power modes from pin and register fields
		for (int i = 0; i < 7; i++) begin
			wr(ADCR_OFS_POWER, ptab[i][12:5]);
			pd = ptab[i][4];
			settle(6);
			`CHK(pwr, ptab[i][3:0])
		end
		$display("test power done");
		// output formats, then disable
		wr(ADCR_OFS_FLAG_CTRL, 8'h00);
		smp = '{valid: 1'b1, over: 1'b0, data: 14'h2100};
		for (int i = 0; i < 4; i++) begin
			wr(ADCR_OFS_FORMAT, ftab[i][21:14]);
			settle(3);
			`CHK(sout.data, ftab[i][13:0])
		end
		wr(ADCR_OFS_FORMAT, 8'h10);
		settle(3);
		`CHK(sout, 16'h0000)
		wr(ADCR_OFS_FORMAT, 8'h00);
		$display("test format done");
		// threshold flag with hysteresis and dwell, upper = 0x100
		wr(ADCR_OFS_UPPER_LOW, 8'h00);
		wr(ADCR_OFS_UPPER_HIGH, 8'h01);
		wr(ADCR_OFS_FLAG_CTRL, 8'h01);
		smp.data = 14'h3000;
		settle(4); `CHK(flag, 1'b1)
		smp.data = 14'h20c0;
		settle(8); `CHK(flag, 1'b1)
		smp.data = 14'h2040;
		settle(8); `CHK(flag, 1'b0)
		smp.data = 14'h3000;
		wr(ADCR_OFS_FLAG_CTRL, 8'h00);
		settle(4); `CHK(flag, 1'b0)
		wr(ADCR_OFS_FLAG_CTRL, 8'h11);
		settle(4); `CHK(flag, 1'b0)
		smp.over = 1'b1;
		settle(4); `CHK(flag, 1'b1)
		wr(ADCR_OFS_FLAG_CTRL, 8'h19);
		settle(4); `CHK(flag, 1'b0)
		smp = '{valid: 1'b1, over: 1'b0, data: 14'h2000};
		wr(ADCR_OFS_FLAG_CTRL, 8'h1d);
		settle(4); `CHK(flag, 1'b1)
		wr(ADCR_OFS_FLAG_CTRL, 8'h00);
		$display("test flag done");
		// dc estimate builds, then freeze and apply the held value
		smp.data = 14'h2100;
		wr(ADCR_OFS_DC_CTRL, 8'h02);
		settle(300);
		wr(ADCR_OFS_DC_CTRL, 8'h42);
		rd(ADCR_OFS_DC_LOW, lo);
		rd(ADCR_OFS_DC_HIGH, hi); `CHK(hi, 8'hff)
		settle(50);
		rd(ADCR_OFS_DC_LOW, rb); `CHK(rb, lo)
		`CHK(sout.data, 14'h2100 + 14'(lo) + (14'(hi) << 8))
		wr(ADCR_OFS_DC_CTRL, 8'h00);
		$display("test dc done");
		// reference and sync handling
		wr(ADCR_OFS_MF_OFFSET, 8'h05);
		wr(ADCR_OFS_SYNCREF, 8'h0a);
		pin(1'b1, 1'b0); `CHK(n_ra, 1)
		`CHK(n_dr, 1)
		`CHK(5'(ph - 5'h05) <= 5'h02, 1'b1)
		wide = 1'b1;
		pin(1'b1, 1'b0); `CHK(n_dr, 1)
		wide = 1'b0;
		wr(ADCR_OFS_SYNCREF, 8'h06);
		pin(1'b1, 1'b0); `CHK(n_dr, 1)
		`CHK(n_ra, 0)
		pin(1'b1, 1'b0); `CHK(n_dr, 0)
		wr(ADCR_OFS_SYNCREF, 8'h06);
		pin(1'b1, 1'b0); `CHK(n_dr, 1)
		wr(ADCR_OFS_SYNCREF, 8'h08);
		pin(1'b1, 1'b0); `CHK(n_ra + n_dr, 0)
		wr(ADCR_OFS_SYNCREF, 8'h11);
		pin(1'b0, 1'b1); `CHK(n_ra, 1)
		`CHK(n_sr > 0, 1'b1)
		wr(ADCR_OFS_SYNCREF, 8'h10);
		pin(1'b0, 1'b1); `CHK(n_ra + n_sr, 0)
		wr(ADCR_OFS_SYNCREF, 8'h01);
		pin(1'b0, 1'b1); `CHK(n_ra, 0)
		$display("test pins done");
		// settings transfer, then a reset in mid-run
		wr(ADCR_OFS_TRANSFER, 8'h01);
		rd(ADCR_OFS_TRANSFER, lo); `CHK(lo, 8'h00)
		wr(ADCR_OFS_SYNCREF, 8'h1f);
		rst_b_i = 1'b0;
		settle(2);
		rst_b_i = 1'b1;
		rd(ADCR_OFS_SYNCREF, lo); `CHK(lo, ADCR_RST_SYNCREF)
		$display("test transfer and reset done");
		end_sim();
	end
endmodule
